// ---- lpb_dev.sv ----
// lpb_dev: device end of the local processor bus port
// assumes: link pins arrive from another domain and are synchronised here;
// user side is a simple word memory port plus system signals
// Contract
// - drive data bus only during reads
// - data bus released during reset
// - processor holds select through access
// - programmable polarity on control pins
// - latch address on latch enable trailing edge
// - strobe assertion starts an access
// - latch tied active passes address through
// - address from data or address lines
// - strobe ignored outside address phase
// - direction sampled only in address phase
// - direction pins combined or separate strobes
// - burst final flag has two modes
// - processor signals ready with ready-in
// - ready-out driven or tri-stated inactive
// - three buffered pci clock copies
// - system supplies a running local clock
// - reset copy follows pci reset
// - delayed reset held until software release
// - masked interrupt-out on host events
// - interrupt-in drives masked pci interrupt
// - test mode floats outputs except ready
// - test pin low unless testing
`timescale 1ns/1ps
module lpb_dev
  import lpb_pkg::*;
(
  input  wire logic                     SYS_CLK_IN,        // local clock
  input  wire logic                     RESETN_IN,         // pci reset, low active
  input  wire logic                     CLK_EN_IN,
  lpb_if.dev                            LINK,
  input  wire logic [lpb_pkg::CFG_W-1:0]  CFG_IN,          // local bus configuration
  input  wire logic                     PCI_CLK_IN,
  input  wire logic                     RST_RELEASE_IN,    // software release pulse
  input  wire logic                     HOST_EVENT_IN,     // host triggered event
  input  wire logic                     IRQ_MASK_IN,       // local interrupt mask
  input  wire logic                     INTA_MASK_IN,      // host interrupt mask
  input  wire logic [lpb_pkg::DATA_W-1:0] RD_DATA_IN,
  output logic      [2:0]               PCI_CLOCK_COPIES_OUT,
  output logic                          RESET_COPY_OUT,
  output logic                          SW_RESET_OUT,
  output logic                          SW_RESET_N_OUT,
  output logic                          INTA_OE_OUT,       // open drain, drive low
  output logic                          ACC_VALID_OUT,
  output logic                          ACC_WRITE_OUT,
  output logic      [lpb_pkg::ADDR_W-1:0] ACC_ADDR_OUT,
  output logic      [3:0]               ACC_BE_OUT,
  output logic      [lpb_pkg::DATA_W-1:0] ACC_WDATA_OUT
);
  import lpb_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam int NS = 13 + ADDR_W + DATA_W;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] pins;
  // sync stages hold zeros, not idle levels, until two edges have passed
  logic [1:0]    prime_q;
  assign pins = {LINK.dq_wire, LINK.addr, LINK.byte_lane_enables, LINK.sel,
                 LINK.ale, LINK.strobe, LINK.wr, LINK.rd,
                 LINK.burst_final_flag, LINK.rdy_in, LINK.test_mode, LINK.irq_in};

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      s1_q    <= '0;
      s2_q    <= '0;
      prime_q <= '0;
    end
    else if (CLK_EN_IN)
    begin
      s1_q    <= pins;
      s2_q    <= s1_q;
      prime_q <= {prime_q[0], 1'b1};
    end
  end

  logic [DATA_W-1:0] dq_s;
  logic [ADDR_W-1:0] adr_s;
  logic [3:0]        be_s;
  logic sel_s, ale_s, stb_s, wr_s, rd_s, bl_s, rdyi_s, test_s, irqi_s;
  assign {dq_s, adr_s, be_s, sel_s, ale_s, stb_s, wr_s, rd_s, bl_s, rdyi_s,
          test_s, irqi_s} = s2_q;

  // ****************************************************************
  // decoded levels
  // ****************************************************************
  logic sel_a, ale_a, stb_a, bl_a, is_wr, is_rd;
  logic [ADDR_W-1:0] pin_addr;
  always_comb
  begin
    sel_a = lpb_act(sel_s, CFG_IN[CFG_SEL_POL]);
    ale_a = lpb_act(ale_s, CFG_IN[CFG_ALE_POL]);
    stb_a = lpb_act(stb_s, CFG_IN[CFG_STB_POL]);
    bl_a  = lpb_act(bl_s, CFG_IN[CFG_BL_POL]);
    pin_addr = CFG_IN[CFG_MUX] ? dq_s[ADDR_HI:ADDR_LO] : adr_s;
    if (CFG_IN[CFG_RW_MODE0 +: 2] == RW_SPLIT)
    begin
      is_wr = !wr_s;
      is_rd = !rd_s;
    end
    else
    begin
      is_wr = (wr_s == CFG_IN[CFG_RW_POL]);
      is_rd = !is_wr;
    end
  end

  // ****************************************************************
  // access state machine
  // ****************************************************************
  lpb_state_t        st_q, st_d;
  logic              ale_prev_q, ale_prev_d;
  logic [ADDR_W-1:0] lat_q, lat_d, cur_q, cur_d;
  logic              dir_wr_q, dir_wr_d;
  logic              rdy_q, rdy_d;
  logic              acc_v_q, acc_v_d;
  logic [ADDR_W-1:0] acc_a_q, acc_a_d;
  logic [DATA_W-1:0] rdat_q, rdat_d;
  logic [ADDR_W-1:0] use_addr;
  logic              done;

  always_comb
  begin
    st_d       = st_q;
    ale_prev_d = ale_a;
    lat_d      = lat_q;
    cur_d      = cur_q;
    dir_wr_d   = dir_wr_q;
    rdy_d      = 1'b0;
    acc_v_d    = 1'b0;
    acc_a_d    = acc_a_q;
    rdat_d     = rdat_q;
    if (ale_prev_q && !ale_a)
      lat_d = pin_addr;
    use_addr = ale_a ? pin_addr : lat_q;
    // final phase per selected burst mode
    done = CFG_IN[CFG_BL_LAST] ? bl_a : !bl_a;
    unique case (st_q)
      LPB_IDLE:
        // strobe only counts here; elsewhere its level is ignored
        if (prime_q[1] && sel_a && stb_a)
        begin
          cur_d    = use_addr;
          dir_wr_d = is_wr && !(is_rd && !is_wr);
          st_d     = LPB_WAIT;
        end
      LPB_WAIT:
      begin
        rdy_d  = 1'b1;
        rdat_d = RD_DATA_IN;
        st_d   = LPB_DATA;
      end
      LPB_DATA:
        if (!sel_a)
          st_d = LPB_IDLE;
        else if (rdyi_s)
        begin
          acc_v_d = 1'b1;
          acc_a_d = cur_q;
          cur_d   = cur_q + ADDR_W'(1);
          st_d    = done ? LPB_IDLE : LPB_WAIT;
        end
        else
          rdy_d = rdy_q;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      st_q       <= LPB_IDLE;
      ale_prev_q <= 1'b0;
      lat_q      <= '0;
      cur_q      <= '0;
      dir_wr_q   <= 1'b0;
      rdy_q      <= 1'b0;
      acc_v_q    <= 1'b0;
      acc_a_q    <= '0;
      rdat_q     <= DATA_ZERO;
    end
    else if (CLK_EN_IN)
    begin
      st_q       <= st_d;
      ale_prev_q <= ale_prev_d;
      lat_q      <= lat_d;
      cur_q      <= cur_d;
      dir_wr_q   <= dir_wr_d;
      rdy_q      <= rdy_d;
      acc_v_q    <= acc_v_d;
      acc_a_q    <= acc_a_d;
      rdat_q     <= rdat_d;
    end
  end

  // ****************************************************************
  // system signals
  // ****************************************************************
  logic hold_q, hold_d, irq_q, irq_d;
  always_comb
  begin
    hold_d = hold_q && !RST_RELEASE_IN;
    // mask wins over a same-cycle event; sticky until masked
    irq_d  = (HOST_EVENT_IN || irq_q) && !IRQ_MASK_IN;
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      hold_q <= 1'b1;
      irq_q  <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      hold_q <= hold_d;
      irq_q  <= irq_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic float_all;
  assign float_all = test_s && !rd_s;

  assign PCI_CLOCK_COPIES_OUT = {3{PCI_CLK_IN}};
  assign RESET_COPY_OUT       = !RESETN_IN;
  assign SW_RESET_OUT         = hold_q;
  assign SW_RESET_N_OUT       = !hold_q;
  assign INTA_OE_OUT          = prime_q[1] && lpb_act(irqi_s, 1'b0)
                                && !INTA_MASK_IN;
  assign ACC_VALID_OUT        = acc_v_q;
  assign ACC_WRITE_OUT        = dir_wr_q;
  assign ACC_ADDR_OUT         = acc_a_q;
  assign ACC_BE_OUT           = be_s;
  assign ACC_WDATA_OUT        = dq_s;

  // reset clears state, so read enable is low under reset too
  assign LINK.dq_dev     = rdat_q;
  assign LINK.dq_dev_oe  = RESETN_IN && !dir_wr_q && st_q != LPB_IDLE
                           && !float_all;
  assign LINK.rdy_out    = rdy_q ? CFG_IN[CFG_RDY_POL] : !CFG_IN[CFG_RDY_POL];
  assign LINK.rdy_out_oe = (rdy_q || CFG_IN[CFG_RDY_DRIVE])
                           && !(float_all && CFG_IN[CFG_TEST_RDY]);
  assign LINK.irq_out    = irq_q ? CFG_IN[CFG_IRQ_POL] : !CFG_IN[CFG_IRQ_POL];
  assign LINK.irq_out_oe = irq_q && !float_all;
endmodule

// ---- lpb_pkg.sv ----
// lpb_pkg: shared constants and types for the local processor bus port
// assumes: included first in compile order, no other dependencies
package lpb_pkg;

  // ****************************************************************
  // widths and positions
  // ****************************************************************
  localparam int DATA_W    = 32;
  localparam int ADDR_HI   = 14;
  localparam int ADDR_LO   = 2;
  localparam int ADDR_W    = ADDR_HI - ADDR_LO + 1;
  localparam int CFG_W     = 17;

  // ****************************************************************
  // configuration word fields (bit positions)
  // ****************************************************************
  localparam int CFG_ALE_POL   = 0;   // 1: latch enable active high
  localparam int CFG_SEL_POL   = 1;   // 1: chip select active high
  localparam int CFG_STB_POL   = 2;   // 1: access strobe active high
  localparam int CFG_BL_POL    = 3;   // 1: burst final active high
  localparam int CFG_RDY_POL   = 4;   // 1: ready-out active high
  localparam int CFG_IRQ_POL   = 5;   // 1: interrupt-out active high
  localparam int CFG_MUX       = 6;   // 1: multiplexed address/data
  localparam int CFG_RW_MODE0  = 7;   // 2-bit direction mode
  localparam int CFG_RW_POL    = 9;   // 1: combined dir high means write
  localparam int CFG_BL_LAST   = 10;  // 1: flag marks final phase only
  localparam int CFG_RDY_DRIVE = 11;  // 1: ready-out driven when inactive
  localparam int CFG_TEST_RDY  = 16;  // 0: ready keeps driving in test

  // defaults: latch high, others low active, tri-state ready
  localparam logic [CFG_W-1:0] CFG_RESET = 17'h0_0001;

  localparam logic [1:0] RW_COMBINED = 2'h0;
  localparam logic [1:0] RW_SPLIT    = 2'h1;

  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {LPB_IDLE, LPB_WAIT, LPB_DATA} lpb_state_t;

  function automatic logic lpb_act(input logic pin, input logic pol);
    lpb_act = (pin == pol);
  endfunction

endpackage

// ---- lpb_if.sv ----
// lpb_if: wires between the processor end and the port end
// assumes: shared data bus resolved here from the device drive enable
`timescale 1ns/1ps
interface lpb_if;
  logic [lpb_pkg::DATA_W-1:0] dq_host;
  logic                       dq_host_oe;
  logic [lpb_pkg::DATA_W-1:0] dq_dev;
  logic                       dq_dev_oe;
  logic [lpb_pkg::DATA_W-1:0] dq_wire;
  logic [lpb_pkg::ADDR_W-1:0] addr;
  logic [3:0]                 byte_lane_enables;
  logic                       sel;
  logic                       ale;
  logic                       strobe;
  logic                       wr;
  logic                       rd;
  logic                       burst_final_flag;
  logic                       rdy_in;
  logic                       rdy_out;
  logic                       rdy_out_oe;
  logic                       irq_out;
  logic                       irq_out_oe;
  logic                       irq_in;
  logic                       test_mode;

  assign dq_wire = dq_dev_oe ? dq_dev : dq_host;

  modport dev (
    input  dq_wire, addr, byte_lane_enables, sel, ale, strobe, wr, rd,
           burst_final_flag, rdy_in, irq_in, test_mode,
    output dq_dev, dq_dev_oe, rdy_out, rdy_out_oe, irq_out, irq_out_oe
  );
  modport host (
    input  dq_wire, rdy_out, rdy_out_oe, irq_out, irq_out_oe,
    output dq_host, dq_host_oe, addr, byte_lane_enables, sel, ale, strobe,
           wr, rd, burst_final_flag, rdy_in, irq_in, test_mode
  );
endinterface

// ---- lpb_host.sv ----
// lpb_host: processor end issuing single-phase accesses only
// assumes: default polarities, non-multiplexed, combined direction pin
`timescale 1ns/1ps
module lpb_host
  import lpb_pkg::*;
(
  input  wire logic                       SYS_CLK_IN,
  input  wire logic                       RESETN_IN,
  input  wire logic                       CLK_EN_IN,
  lpb_if.host                             LINK,
  input  wire logic                       REQ_IN,
  input  wire logic                       REQ_WRITE_IN,
  input  wire logic [lpb_pkg::ADDR_W-1:0] REQ_ADDR_IN,
  input  wire logic [lpb_pkg::DATA_W-1:0] REQ_WDATA_IN,
  input  wire logic                       IRQ_REQ_IN,
  output logic                            BUSY_OUT,
  output logic                            DONE_OUT,
  output logic      [lpb_pkg::DATA_W-1:0] RDATA_OUT,
  output logic                            IRQ_SEEN_OUT
);
  import lpb_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [DATA_W+1:0] s1_q, s2_q;
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else if (CLK_EN_IN)
    begin
      s1_q <= {LINK.dq_wire, LINK.rdy_out_oe && !LINK.rdy_out,
               LINK.irq_out_oe && !LINK.irq_out};
      s2_q <= s1_q;
    end
  end

  // ****************************************************************
  // access sequencer
  // ****************************************************************
  typedef enum logic [1:0] {LPH_IDLE, LPH_STB, LPH_ADDR, LPH_DATA} lpb_hstate_t;
  lpb_hstate_t       st_q, st_d;
  logic              wr_q, wr_d, done_q, done_d;
  logic [ADDR_W-1:0] a_q, a_d;
  logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;

  always_comb
  begin
    st_d   = st_q;
    wr_d   = wr_q;
    a_d    = a_q;
    wd_d   = wd_q;
    rd_d   = rd_q;
    done_d = 1'b0;
    unique case (st_q)
      LPH_IDLE:
        if (REQ_IN)
        begin
          st_d = LPH_STB;
          wr_d = REQ_WRITE_IN;
          a_d  = REQ_ADDR_IN;
          wd_d = REQ_WDATA_IN;
        end
      LPH_STB:
        st_d = LPH_ADDR;
      LPH_ADDR:
        if (s2_q[1])
        begin
          // data word was synchronised alongside the ready that came with it
          st_d = LPH_DATA;
          rd_d = s2_q[DATA_W+1:2];
        end
      LPH_DATA:
      begin
        // select held until the whole access is over
        st_d   = LPH_IDLE;
        done_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      st_q   <= LPH_IDLE;
      wr_q   <= 1'b0;
      a_q    <= '0;
      wd_q   <= DATA_ZERO;
      rd_q   <= DATA_ZERO;
      done_q <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      st_q   <= st_d;
      wr_q   <= wr_d;
      a_q    <= a_d;
      wd_q   <= wd_d;
      rd_q   <= rd_d;
      done_q <= done_d;
    end
  end

  assign LINK.sel               = !(st_q != LPH_IDLE);
  assign LINK.ale               = 1'b1;
  // one-cycle strobe: a held one would restart the device once it finishes
  assign LINK.strobe            = !(st_q == LPH_STB);
  assign LINK.wr                = !wr_q;
  assign LINK.rd                = wr_q;
  assign LINK.burst_final_flag  = 1'b1;                          // single phase
  assign LINK.rdy_in            = (st_q != LPH_IDLE);
  assign LINK.addr              = a_q;
  assign LINK.byte_lane_enables = 4'h0;
  assign LINK.dq_host           = wd_q;
  assign LINK.dq_host_oe        = wr_q && st_q != LPH_IDLE;
  assign LINK.irq_in            = !IRQ_REQ_IN;
  assign LINK.test_mode         = 1'b0;
  assign BUSY_OUT               = st_q != LPH_IDLE;
  assign DONE_OUT               = done_q;
  assign RDATA_OUT              = rd_q;
  assign IRQ_SEEN_OUT           = s2_q[0];
endmodule

// ---- lpb_link_monitor.sv ----
// lpb_link_monitor: assertions on the link joining the two design ends
// assumes: default polarities on this link, one local clock domain
`timescale 1ns/1ps
module lpb_link_monitor (
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic dq_host_oe,
  input wire logic dq_dev_oe,
  input wire logic sel,
  input wire logic strobe,
  input wire logic rdy_out,
  input wire logic rdy_out_oe,
  input wire logic irq_out,
  input wire logic irq_out_oe
);
  // ****
  // link checks
  // ****
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  logic rdy_act;
  assign rdy_act = rdy_out_oe && !rdy_out;

  sequence s_sel_start;
    $fell(sel);
  endsequence
  sequence s_rdy_soon;
    ##[1:12] rdy_act;
  endsequence

  a_one_driver: assert property (!(dq_host_oe && dq_dev_oe))
    else $error("data bus driven from both ends");
  a_dev_in_access: assert property (dq_dev_oe |-> !sel)
    else $error("data driven outside an access");
  a_reset_float: assert property ($rose(RESETN_IN) |-> !dq_dev_oe [*3])
    else $error("data driven right after reset");
  a_sel_covers_stb: assert property (!strobe |-> !sel)
    else $error("strobe active without select");
  a_rdy_answers: assert property (s_sel_start |-> s_rdy_soon)
    else $error("no ready after access start");
  a_rdy_not_early: assert property (s_sel_start |-> !rdy_act [*3])
    else $error("ready before start was synchronised");
  a_rdy_in_access: assert property ($rose(rdy_act) |-> !sel && !$past(sel, 2))
    else $error("ready outside an access");
  a_rdy_float: assert property (rdy_out_oe |-> !rdy_out)
    else $error("ready driven while inactive");
  a_irq_float: assert property (irq_out_oe |-> !irq_out)
    else $error("interrupt driven while inactive");
endmodule

// ---- local_processor_bus_port_tb.sv ----
// local_processor_bus_port_tb: host and device ends on one link, and a
// second device end driven by hand for modes the host end cannot use
// assumes: package, interface, both ends and monitor compiled first
`timescale 1ns/1ps
module local_processor_bus_port_tb;
  import lpb_pkg::*;
  typedef struct packed {logic w; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d;} lpb_acc_t;
  logic              clk, rstn, pclk, rel, hev, imask, amask, req, reqw, irqr;
  logic              rco, swr, swrn, inta, av, aw, av2, aw2, busy, done, iseen, rdy2;
  logic [ADDR_W-1:0] reqa, aa, aa2;
  logic [DATA_W-1:0] reqd, rdd, rdd2, ad, ad2, rdo;
  logic [CFG_W-1:0]  cfg2;
  logic [2:0]        pcc;
  logic [DATA_W:0]   dn, done_q[$];
  lpb_acc_t          acc_q[$], acc2_q[$];
  int                err_total, samples_checked;
  localparam logic [CFG_W-1:0] CFGS [6] = '{17'h0_0001, 17'h0_003E, 17'h0_0041,
    17'h0_0081, 17'h0_0201, 17'h0_0C01};

  lpb_if l1();
  lpb_if l2();
  lpb_dev lpb_dev_inst (.SYS_CLK_IN(clk), .RESETN_IN(rstn), .CLK_EN_IN(1'b1), .LINK(l1.dev),
    .CFG_IN(CFG_RESET), .PCI_CLK_IN(pclk), .RST_RELEASE_IN(rel), .HOST_EVENT_IN(hev),
    .IRQ_MASK_IN(imask), .INTA_MASK_IN(amask), .RD_DATA_IN(rdd), .PCI_CLOCK_COPIES_OUT(pcc),
    .RESET_COPY_OUT(rco), .SW_RESET_OUT(swr), .SW_RESET_N_OUT(swrn), .INTA_OE_OUT(inta),
    .ACC_VALID_OUT(av), .ACC_WRITE_OUT(aw), .ACC_ADDR_OUT(aa), .ACC_BE_OUT(),
    .ACC_WDATA_OUT(ad));
  lpb_dev lpb_dev_inst_b (.SYS_CLK_IN(clk), .RESETN_IN(rstn), .CLK_EN_IN(1'b1),
    .LINK(l2.dev), .CFG_IN(cfg2), .PCI_CLK_IN(pclk), .RST_RELEASE_IN(rel),
    .HOST_EVENT_IN(hev), .IRQ_MASK_IN(imask), .INTA_MASK_IN(amask), .RD_DATA_IN(rdd2),
    .PCI_CLOCK_COPIES_OUT(), .RESET_COPY_OUT(), .SW_RESET_OUT(), .SW_RESET_N_OUT(),
    .INTA_OE_OUT(), .ACC_VALID_OUT(av2), .ACC_WRITE_OUT(aw2), .ACC_ADDR_OUT(aa2),
    .ACC_BE_OUT(), .ACC_WDATA_OUT(ad2));
  lpb_host lpb_host_inst (.SYS_CLK_IN(clk), .RESETN_IN(rstn), .CLK_EN_IN(1'b1),
    .LINK(l1.host), .REQ_IN(req), .REQ_WRITE_IN(reqw), .REQ_ADDR_IN(reqa),
    .REQ_WDATA_IN(reqd), .IRQ_REQ_IN(irqr), .BUSY_OUT(busy), .DONE_OUT(done),
    .RDATA_OUT(rdo), .IRQ_SEEN_OUT(iseen));
  lpb_link_monitor lpb_link_monitor_inst (.SYS_CLK_IN(clk), .RESETN_IN(rstn),
    .dq_host_oe(l1.dq_host_oe), .dq_dev_oe(l1.dq_dev_oe), .sel(l1.sel), .strobe(l1.strobe),
    .rdy_out(l1.rdy_out), .rdy_out_oe(l1.rdy_out_oe), .irq_out(l1.irq_out),
    .irq_out_oe(l1.irq_out_oe));

  assign rdy2 = l2.rdy_out_oe && (l2.rdy_out === cfg2[CFG_RDY_POL]);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    pclk = 1'b0;
    forever #7 pclk = ~pclk;
  end

  // ****
  // checking
  // ****
  task automatic chk_bit(string n, logic e, logic g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %b, seen %b", n, e, g);
    end
  endtask
  task automatic chk_val(string n, logic [63:0] e, logic [63:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_for(ref logic s, input logic v, input string n);
    for (int i = 0; i < 60 && s !== v; i++)
      @(negedge clk);
    chk_bit(n, v, s);
    if (s !== v)
      wrap_up();
  endtask
  task automatic take(ref lpb_acc_t q[$], input lpb_acc_t g, input string n);
    lpb_acc_t e;
    e = q.size() ? q.pop_front() : ~g;
    if (!e.w)
      g.d = e.d; // read lanes carry nothing
    chk_val(n, 64'(e), 64'(g));
  endtask

  always @(negedge clk)
  begin
    if (av === 1'b1)
      take(acc_q, {aw, aa, ad}, "access");
    if (av2 === 1'b1)
      take(acc2_q, {aw2, aa2, ad2}, "second access");
    if (done === 1'b1)
    begin
      dn = done_q.size() ? done_q.pop_front() : {1'b1, ~rdo};
      if (dn[DATA_W])
        chk_val("read data", 64'(dn[DATA_W-1:0]), 64'(rdo));
    end
  end

  // ****
  // stimulus
  // ****
  task automatic host_op(input logic w);
    @(negedge clk);
    reqw = w;
    reqa = ADDR_W'($urandom);
    reqd = $urandom;
    rdd = $urandom;
    req = 1'b1;
    acc_q.push_back({w, reqa, reqd});
    done_q.push_back({!w, rdd});
    wait_for(busy, 1'b1, "host busy");
    req = 1'b0;
    wait_for(busy, 1'b0, "host idle");
  endtask
  task automatic idle2(input logic [CFG_W-1:0] c);
    l2.sel = !c[CFG_SEL_POL];
    l2.strobe = !c[CFG_STB_POL];
    l2.ale = c[CFG_ALE_POL] ^ c[CFG_MUX];
    l2.burst_final_flag = !c[CFG_BL_POL];
    l2.rdy_in = 1'b0;
    l2.dq_host_oe = 1'b0;
    l2.dq_host = $urandom; // released lines show no stale value
    l2.byte_lane_enables = 4'($urandom);
  endtask
  task automatic dev2_op(input logic [CFG_W-1:0] c, input logic w, input logic abort);
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic              dir;
    a = ADDR_W'($urandom);
    d = $urandom;
    dir = c[CFG_RW_MODE0] ? !w : (c[CFG_RW_POL] ~^ w);
    @(negedge clk);
    rstn = 1'b0; // polarity changes only while held in reset
    cfg2 = c;
    rdd2 = d;
    idle2(c);
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    chk_bit("held reset again", 1'b1, swr);
    repeat (2) @(negedge clk);
    l2.sel = c[CFG_SEL_POL];
    l2.ale = c[CFG_ALE_POL];
    l2.addr = c[CFG_MUX] ? ~a : a;
    l2.dq_host = c[CFG_MUX] ? {17'($urandom), a, 2'b00} : d;
    l2.dq_host_oe = c[CFG_MUX] || w;
    l2.wr = dir;
    l2.rd = c[CFG_RW_MODE0] ? w : dir;
    l2.burst_final_flag = c[CFG_BL_POL] ~^ c[CFG_BL_LAST];
    if (c[CFG_MUX])
    begin
      @(negedge clk);
      l2.ale = !c[CFG_ALE_POL];
      repeat (3) @(negedge clk);
      l2.dq_host = d;
      l2.dq_host_oe = w;
    end
    l2.strobe = c[CFG_STB_POL];
    wait_for(rdy2, 1'b1, "second ready");
    l2.strobe = !c[CFG_STB_POL];
    l2.wr = !l2.wr;
    l2.rd = !l2.rd;
    chk_bit("device drive", !w, l2.dq_dev_oe);
    if (!w)
      chk_val("read bus", 64'(d), 64'(l2.dq_wire));
    if (abort)
      l2.sel = !c[CFG_SEL_POL];
    else
    begin
      acc2_q.push_back({w, a, d});
      l2.rdy_in = 1'b1;
      wait_for(av2, 1'b1, "second access");
      l2.rdy_in = 1'b0;
      repeat (6)
      begin
        @(negedge clk);
        chk_bit("ready after last phase", 1'b0, rdy2);
      end
      l2.sel = !c[CFG_SEL_POL];
    end
    repeat (4) @(negedge clk);
    chk_bit("idle ready drive", c[CFG_RDY_DRIVE], l2.rdy_out_oe);
    chk_bit("idle data drive", 1'b0, l2.dq_dev_oe);
  endtask

  initial
  begin
    err_total = 0;
    samples_checked = 0;
    {rel, hev, imask, amask, req, reqw, irqr, rstn} = '0;
    {reqa, reqd, rdd, rdd2} = '0;
    cfg2 = CFG_RESET;
    l2.addr = '0;
    {l2.wr, l2.rd, l2.irq_in, l2.test_mode} = 4'hE; // interrupt idle, no test
    void'($urandom(32'h1100d156));
    idle2(CFG_RESET);
    repeat (5) @(negedge clk);
    chk_bit("reset copy", 1'b1, rco);
    chk_bit("data drive in reset", 1'b0, l1.dq_dev_oe);
    rstn = 1'b1;
    @(posedge pclk);
    #1;
    chk_val("clock copies", 64'({3{pclk}}), 64'(pcc));
    chk_bit("reset copy", 1'b0, rco);
    chk_bit("held reset", 1'b1, swr);
    chk_bit("held reset low", 1'b0, swrn);
    repeat (12) host_op(1'($urandom));
    irqr = 1'b1;
    wait_for(inta, 1'b1, "pci interrupt");
    amask = 1'b1;
    #1;
    chk_bit("masked pci interrupt", 1'b0, inta);
    hev = 1'b1;
    @(negedge clk);
    hev = 1'b0;
    wait_for(iseen, 1'b1, "local interrupt");
    imask = 1'b1;
    wait_for(iseen, 1'b0, "masked interrupt");
    rel = 1'b1;
    @(negedge clk);
    rel = 1'b0;
    wait_for(swr, 1'b0, "reset release");
    chk_bit("released reset low", 1'b1, swrn);
    for (int i = 0; i < 12; i++)
      dev2_op(CFGS[i / 2], i[0], 1'b0);
    dev2_op(CFG_RESET, 1'b0, 1'b1);
    imask = 1'b0;
    hev = 1'b1;
    @(negedge clk);
    hev = 1'b0;
    cfg2 = 17'h1_0801;
    l2.test_mode = 1'b1;
    l2.rd = 1'b0;
    repeat (3) @(negedge clk);
    chk_bit("test data drive", 1'b0, l2.dq_dev_oe);
    chk_bit("test ready drive", 1'b0, l2.rdy_out_oe);
    chk_bit("test interrupt drive", 1'b0, l2.irq_out_oe);
    cfg2 = 17'h0_0801;
    @(negedge clk);
    chk_bit("test ready kept", 1'b1, l2.rdy_out_oe);
    l2.test_mode = 1'b0;
    repeat (4) @(negedge clk);
    chk_bit("interrupt drive", 1'b1, l2.irq_out_oe);
    chk_val("pending notes", 64'h0, 64'(acc_q.size() + acc2_q.size() + done_q.size()));
    wrap_up();
  end
endmodule
